// ===== core/clk_ref_pkg.sv
// Purpose: shared constants for master clock select and reference enable
// Assumes: 16-bit registers in the low half of a 32-bit APB word
// Notes: register indices are scaled by four to form byte addresses
package clk_ref_pkg;
   // ==========================================================
   // register map
   localparam logic [11:0] MODE_IDX = 12'h001;
   localparam logic [11:0] SETUP0_IDX = 12'h020;
   localparam logic [11:0] MODE_ADDR = 12'(MODE_IDX * 4);
   localparam logic [11:0] SETUP0_ADDR = 12'(SETUP0_IDX * 4);
   localparam logic [15:0] MODE_RESET = 16'h2000;
   localparam logic [15:0] SETUP0_RESET = 16'h1000;
   localparam logic [15:0] MODE_MASK = 16'hAF7C;
   localparam logic [15:0] SETUP0_MASK = 16'h1F30;
   // ==========================================================
   // field positions
   localparam int REF_EN_BIT = 15;
   localparam int SINGLE_CYC_BIT = 13;
   localparam int CLKSEL_LSB = 2;
   localparam int REFSEL_LSB = 4;
   // ==========================================================
   // clock source encodings
   typedef enum logic [1:0] {
      SRC_INT = 2'b00,
      SRC_INT_OUT = 2'b01,
      SRC_EXT = 2'b10,
      SRC_XTAL = 2'b11
   } clk_src_t;
   // ==========================================================
   // rates
   localparam int CLK_HZ = 100_000_000;
   localparam int OSC_HZ = 16_000_000;
   localparam int MCLK_HZ = 4_000_000;
   localparam int MCLK_DIV = OSC_HZ / MCLK_HZ;
   localparam int ODR_DIV = 64;
endpackage : clk_ref_pkg

// ===== core/clk_sel_if.sv
// Purpose: carrier between the control top and the master clock divider
// Assumes: all signals on pclk
// Notes: edges are one-cycle pulses from synchronised pins
`timescale 1ns/10ps
interface clk_sel_if;
   logic [1:0] src_sel;
   logic osc_edge;
   logic xtal_edge;
   logic ext_edge;
   logic mclk_tick;
   modport ctrl (output src_sel, output osc_edge, output xtal_edge, output ext_edge,
                 input mclk_tick);
   modport div (input src_sel, input osc_edge, input xtal_edge, input ext_edge,
                output mclk_tick);
endinterface : clk_sel_if

// ===== core/mclk_divider.sv
// Purpose: derive the master clock tick from the selected source
// Assumes: source edges are synchronised one-cycle pulses
// Notes: the count restarts whenever the source changes
`timescale 1ns/10ps
module mclk_divider #(
   parameter int DIV = clk_ref_pkg::MCLK_DIV
) (
   input wire logic pclk,
   input wire logic presetn,
   clk_sel_if.div bus
);
   import clk_ref_pkg::*;
   localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(DIV - 1);

   logic [CNT_W-1:0] cnt_reg;
   logic tick_reg;
   logic [1:0] prev_reg;

   // ==========================================================
   // source decode
   wire is_ext = (bus.src_sel == SRC_EXT);
   wire edge16 = (bus.src_sel == SRC_XTAL) ? bus.xtal_edge : bus.osc_edge;
   wire restart = (bus.src_sel != prev_reg);
   wire wrap = (cnt_reg == CNT_TOP);

   // divide 16 MHz edges by four
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         prev_reg <= SRC_INT;
      end else begin
         prev_reg <= bus.src_sel;
         if (restart) begin
            cnt_reg <= '0;
         end else if (!is_ext && edge16) begin
            cnt_reg <= wrap ? '0 : cnt_reg + CNT_W'(1);
         end
      end
   end

   // tick: divided edge, or external edge passed straight through
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= is_ext ? bus.ext_edge : (edge16 && wrap && !restart);
      end
   end

   assign bus.mclk_tick = tick_reg;
endmodule : mclk_divider

// ===== core/adc_master_clock_and_ref_select.sv
// Purpose: master clock source select and internal reference enable, APB slave
// Assumes: oscillator and clock pins are asynchronous to pclk
// Notes: registers sit at four times their index; pready answers in one access cycle
`timescale 1ns/10ps
module adc_master_clock_and_ref_select #(
   parameter int ODR_RATIO = clk_ref_pkg::ODR_DIV
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_16m_in,
   input wire logic crystal_in_pin,
   input wire logic crystal_out_clock_io_pin_in,
   output logic crystal_out_clock_io_pin_out,
   output logic crystal_out_clock_io_pin_oe,
   output logic [1:0] master_clock_source_select,
   output logic mclk_tick,
   output logic odr_tick,
   output logic reference_enable,
   output logic [1:0] reference_select,
   output logic single_cycle_settle
);
   import clk_ref_pkg::*;
   localparam int ODR_W = (ODR_RATIO > 1) ? $clog2(ODR_RATIO) : 1;
   localparam logic [ODR_W-1:0] ODR_TOP = ODR_W'(ODR_RATIO - 1);

   logic [15:0] mode_reg;
   logic [15:0] setup_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [2:0] sync3_reg;
   logic [ODR_W-1:0] odr_cnt_reg;
   logic odr_tick_reg;
   logic pin_out_reg;
   logic pin_oe_reg;

   clk_sel_if sel_bus ();

   // ==========================================================
   // APB decode
   wire hit_mode = (paddr == MODE_ADDR);
   wire hit_setup = (paddr == SETUP0_ADDR);
   wire hit_any = hit_mode | hit_setup;
   wire setup_ph = psel & ~penable;
   wire access = psel & penable & pready_reg;
   wire mode_wr = access & pwrite & hit_mode;
   wire setup_wr = access & pwrite & hit_setup;
   wire [15:0] mode_next = pwdata[15:0] & MODE_MASK;
   wire [15:0] setup_next = pwdata[15:0] & SETUP0_MASK;
   wire [31:0] rd_mux = hit_mode ? {16'h0000, mode_reg} :
                        hit_setup ? {16'h0000, setup_reg} : 32'h0000_0000;

   // answer one cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup_ph;
         pslverr_reg <= setup_ph & ~hit_any;
         prdata_reg <= (setup_ph & ~pwrite) ? rd_mux : prdata_reg;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_RESET;
         setup_reg <= SETUP0_RESET;
      end else begin
         if (mode_wr) mode_reg <= mode_next;
         if (setup_wr) setup_reg <= setup_next;
      end
   end

   // ==========================================================
   // pin synchronisers: osc, crystal, external clock
   wire [2:0] pins_raw = {crystal_out_clock_io_pin_in, crystal_in_pin, osc_16m_in};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // rising edges after synchronisation
   wire [2:0] rise = sync2_reg & ~sync3_reg;
   wire [1:0] src = mode_reg[CLKSEL_LSB +: 2];
   assign sel_bus.src_sel = src;
   assign sel_bus.osc_edge = rise[0];
   assign sel_bus.xtal_edge = rise[1];
   assign sel_bus.ext_edge = rise[2] & (src == SRC_EXT);

   mclk_divider #(.DIV(MCLK_DIV)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .bus(sel_bus)
   );

   // ==========================================================
   // output data rate tick from master clock ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odr_cnt_reg <= '0;
         odr_tick_reg <= 1'b0;
      end else begin
         odr_tick_reg <= sel_bus.mclk_tick & (odr_cnt_reg == ODR_TOP);
         if (sel_bus.mclk_tick) begin
            odr_cnt_reg <= (odr_cnt_reg == ODR_TOP) ? '0 : odr_cnt_reg + ODR_W'(1);
         end
      end
   end

   // clock-out drive on the shared pin
   wire drive_out = (src == SRC_INT_OUT);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         pin_oe_reg <= drive_out;
         pin_out_reg <= drive_out & sync2_reg[0];
      end
   end

   // ==========================================================
   // outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign mclk_tick = sel_bus.mclk_tick;
   assign odr_tick = odr_tick_reg;
   assign crystal_out_clock_io_pin_out = pin_out_reg;
   assign crystal_out_clock_io_pin_oe = pin_oe_reg;
   assign master_clock_source_select = mode_reg[CLKSEL_LSB +: 2];
   assign reference_enable = mode_reg[REF_EN_BIT];
   assign reference_select = setup_reg[REFSEL_LSB +: 2];
   assign single_cycle_settle = mode_reg[SINGLE_CYC_BIT];

   // ==========================================================
   // checking helpers
   logic wrote_mode;
   logic [2:0] h_cnt;
   logic h_stable;
   logic [1:0] h_src;
   wire h_edge16 = (src == SRC_XTAL) ? rise[1] : rise[0];
   wire [1:0] wr_clk = pwdata[CLKSEL_LSB +: 2];
   wire wr_ref = pwdata[REF_EN_BIT];
   wire [1:0] wr_refsel = pwdata[REFSEL_LSB +: 2];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrote_mode <= 1'b0;
         h_cnt <= 3'h0;
         h_stable <= 1'b0;
         h_src <= SRC_INT;
      end else begin
         h_src <= src;
         if (mode_wr) wrote_mode <= 1'b1;
         if (src != h_src) begin
            h_cnt <= 3'h0;
            h_stable <= 1'b0;
         end else if (sel_bus.mclk_tick) begin
            h_cnt <= {2'b00, h_edge16};
            h_stable <= (src != SRC_EXT); // external ticks leave no 16 MHz count
         end else if (h_edge16) begin
            h_cnt <= h_cnt + 3'h1;
         end
      end
   end

   sequence mode_write_s;
      mode_wr;
   endsequence
   sequence setup_write_s;
      setup_wr;
   endsequence

   clk_field_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_write_s |=> (master_clock_source_select == $past(wr_clk)))
      else $error("clock select did not follow write");
   reset_int_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wrote_mode |-> (src == SRC_INT) && !crystal_out_clock_io_pin_oe)
      else $error("not on internal oscillator after reset");
   osc_div_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_bus.mclk_tick && h_stable && src != SRC_XTAL && src != SRC_EXT)
      |-> (h_cnt == 3'(MCLK_DIV)))
      else $error("oscillator not divided by four");
   xtal_div_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_bus.mclk_tick && h_stable && src == SRC_XTAL) |-> (h_cnt == 3'(MCLK_DIV)))
      else $error("crystal not divided by four");
   ext_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_bus.ext_edge && $stable(src)) |=> mclk_tick)
      else $error("external edge not passed to master clock");
   odr_scale_a: assert property (@(posedge pclk) disable iff (!presetn)
      odr_tick |-> $past(sel_bus.mclk_tick))
      else $error("rate tick without master clock tick");
   clk_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      (drive_out && $stable(src)) |=> crystal_out_clock_io_pin_oe
      && (crystal_out_clock_io_pin_out == $past(sync2_reg[0])))
      else $error("oscillator not driven on clock pin");
   ref_en_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_write_s |=> (reference_enable == $past(wr_ref)))
      else $error("reference enable did not follow write");
   ref_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup_write_s |=> (reference_select == $past(wr_refsel)))
      else $error("reference select did not follow write");
   ref_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wrote_mode |-> !reference_enable && single_cycle_settle)
      else $error("reference enabled before software set it");
endmodule : adc_master_clock_and_ref_select

// ===== tb/clk_src_model.sv
// Purpose: far-side clock sources: internal oscillator, crystal, external clock
// Assumes: 16 MHz oscillator and crystal, 2 MHz external clock
// Notes: external clock stands still low while switched off
`timescale 1ns/10ps
module clk_src_model #(
   parameter real XTAL_START_NS = 2000.0
) (
   input wire logic xtal_on,
   input wire logic ext_on,
   output logic osc_out,
   output logic xtal_out,
   output logic ext_out
);
   // ==========================================================
   // internal oscillator, free running at 16 MHz
   initial begin
      osc_out = 1'b0;
      forever #31.25 osc_out = ~osc_out;
   end
   // crystal holds still until its amplitude has built up
   initial begin
      xtal_out = 1'b0;
      wait (xtal_on === 1'b1);
      #(XTAL_START_NS);
      forever #31.25 xtal_out = ~xtal_out;
   end
   // external clock only toggles while enabled
   initial begin
      ext_out = 1'b0;
      forever begin
         #250;
         ext_out = (ext_on === 1'b1) ? ~ext_out : 1'b0;
      end
   end
endmodule : clk_src_model

// ===== tb/tb_adc_master_clock_and_ref_select.sv
// Purpose: self-checking bench for master clock select and reference enable
// Assumes: ODR_RATIO set to 4, APB answer awaited under a bound
// Notes: rows give register writes and expected tick counts
`timescale 1ns/10ps
module tb_adc_master_clock_and_ref_select;
   import clk_ref_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e; int t;} row_t;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, osc, xtal, ext, pin_out, pin_oe, pin_lvl, mck, odr, ref_en, scs;
   logic ext_on = 1'b0;
   logic [1:0] src, rsel;
   int err_count = 0, cmp_count = 0, nm, no, np;
   logic pin_q;
   row_t rows[9] = '{
      '{MODE_ADDR, 32'hFFFF, 32'hAF7C, 1'b0, 0}, '{SETUP0_ADDR, 32'hFFFF, 32'h1F30, 1'b0, 0},
      '{12'h008, 32'hFFFF, 32'h0, 1'b1, 0}, '{MODE_ADDR, 32'h2000, 32'h2000, 1'b0, 160},
      '{MODE_ADDR, 32'h2004, 32'h2004, 1'b0, 160}, '{MODE_ADDR, 32'h2008, 32'h2008, 1'b0, 80},
      '{MODE_ADDR, 32'h200C, 32'h200C, 1'b0, 160}, '{MODE_ADDR, 32'h8000, 32'h8000, 1'b0, 160},
      '{SETUP0_ADDR, 32'h0020, 32'h0020, 1'b0, 0}};
   always #5 pclk = ~pclk;
   // shared pin level from both drivers
   assign pin_lvl = pin_oe ? pin_out : ext;
   clk_src_model src_u (.xtal_on(1'b1), .ext_on(ext_on), .osc_out(osc), .xtal_out(xtal),
                        .ext_out(ext));
   adc_master_clock_and_ref_select #(.ODR_RATIO(4)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_16m_in(osc),
      .crystal_in_pin(xtal), .crystal_out_clock_io_pin_in(pin_lvl),
      .crystal_out_clock_io_pin_out(pin_out), .crystal_out_clock_io_pin_oe(pin_oe),
      .master_clock_source_select(src), .mclk_tick(mck), .odr_tick(odr),
      .reference_enable(ref_en), .reference_select(rsel), .single_cycle_settle(scs));
   // ==========================================================
   // reporting
   task end_of_test;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         err_count++;
      end
   endtask : check
   // ==========================================================
   // apb transfer, called just after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (pready !== 1'b1) begin
         err_count++;
         end_of_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // count master clock and data rate ticks over 4000 cycles
   task count_ticks;
      nm = 0;
      no = 0;
      np = 0;
      pin_q = 1'b0;
      repeat (4000) begin
         @(posedge pclk);
         nm += (mck === 1'b1);
         no += (odr === 1'b1);
         np += (pin_out === 1'b1 && pin_q !== 1'b1);
         pin_q = pin_out;
      end
   endtask : count_ticks
   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("src", {30'h0, src}, 32'h0);
      check("ref_en", {31'h0, ref_en}, 32'h0);
      apb(1'b0, MODE_ADDR, 32'h0);
      check("mode", rd, 32'h2000);
      $display("reset test done");
      foreach (rows[i]) begin
         ext_on <= (rows[i].d[3:2] == 2'b10);
         apb(1'b1, rows[i].a, rows[i].d);
         check("werr", {31'h0, er}, {31'h0, rows[i].e});
         apb(1'b0, rows[i].a, 32'h0);
         check("rdata", rd, rows[i].r);
         check("rerr", {31'h0, er}, {31'h0, rows[i].e});
         if (rows[i].a == MODE_ADDR) begin
            check("src", {30'h0, src}, {30'h0, rows[i].r[3:2]});
            check("ref_en", {31'h0, ref_en}, {31'h0, rows[i].r[15]});
            check("oe", {31'h0, pin_oe}, {31'h0, rows[i].r[3:2] == 2'b01});
         end
         if (rows[i].a == SETUP0_ADDR) begin
            check("rsel", {30'h0, rsel}, {30'h0, rows[i].r[5:4]});
         end
         if (rows[i].t > 0) begin
            repeat (20) @(posedge pclk);
            count_ticks();
            check("mclk", {31'h0, nm >= rows[i].t - 2 && nm <= rows[i].t + 2}, 32'h1);
            check("odr", {31'h0, no >= nm / 4 - 2 && no <= nm / 4 + 2}, 32'h1);
            // 16 MHz oscillator gives 640 rises in 4000 cycles when driven out
            check("pin", {31'h0, (rows[i].r[3:2] == 2'b01) ? (np >= 636 && np <= 644)
                                                           : (np == 0)}, 32'h1);
         end
         $display("row %0d done", i);
      end
      // internal reference switched off again for an external reference
      apb(1'b1, MODE_ADDR, 32'h2008);
      check("ref_en", {31'h0, ref_en}, 32'h0);
      // reset in mid-run while the external clock is selected
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("src", {30'h0, src}, 32'h0);
      check("scs", {31'h0, scs}, 32'h1);
      repeat (20) @(posedge pclk);
      count_ticks();
      check("mclk", {31'h0, nm >= 158 && nm <= 162}, 32'h1);
      check("pin", {31'h0, np == 0}, 32'h1);
      $display("mid-run reset test done");
      end_of_test();
   end
endmodule : tb_adc_master_clock_and_ref_select
